// File: hw/wps_top.sv
// Purpose: playback sequencer: counters, run modes, sequence table, outputs
// Assumes: ref_clk is the sample clock divided by four; one memory word per cycle
// Notes: registers on a plain strobe port, read data one cycle later
// Behaviour
// - At start, load address counter with waveform start and length counter with length.
// - Counters step once per quarter-rate clock, four samples per step.
// - Replay waveform the loaded repeat count (a count of 0 plays once) before proceeding or stopping.
// - Length at least 960, within memory, multiple of four; others rejected. Sequence entry lengths (R_SEQ_LEN) are stored unchecked.
// - Each point holds 8-bit value plus 2 marker bits, read together.
// - Serializer delivers samples to the DAC at up to 4.2 GS/s.
// - Continuous mode repeats without break, ignoring triggers.
// - Triggered mode plays once per trigger from pin, manual or remote.
// - Gated mode outputs only while gate is true; halts when false.
// - Sequenced mode steps entries in order, advanced by triggers, events, jumps.
// - Trigger control starts, stops or advances address control per run mode.
// - Events in sequenced mode jump to another entry or stop output.
// - Output, complement and marker enables change without interrupting playback.
// - Clearing run stops output and clears the run indicator.
// - Mixing mode outputs weighted sum of waveforms A and B per point.
// - Master echoes its trigger to slave; slave starts one cycle after master, run and stop are per unit.
// - Trigger edge or gate level selectable positive or negative.
// - Internal trigger source fires periodically, interval 1.0 us to 10.0 s.
`timescale 1ns/100ps
`default_nettype none
module wps_top #(
   parameter int ADDR_W = wps_pkg::ADDR_W,
   parameter int SEQ_DEPTH = 16,
   parameter longint TRIG_MIN = wps_pkg::TRIG_MIN_CYC,
   parameter longint TRIG_MAX = wps_pkg::TRIG_MAX_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic external_trigger_input,
   input wire logic event_input,
   input wire logic force_trigger,
   input wire logic force_event,
   input wire logic sync_trigger_in,
   output logic sync_trigger_out,
   output wps_pkg::wps_word_t dac_word,
   output logic channel_output_enable,
   output logic channel_output_n_enable,
   output logic marker_output_enable,
   output logic running
);
   import wps_pkg::*;
   localparam int MEM_DW = LANES * (SAMPLE_W + MARK_W);

   logic [31:0] ctrl_reg;
   logic [ADDR_W-1:0] start_reg;
   logic [LEN_W-1:0] len_reg;
   logic [REP_W-1:0] rep_reg;
   logic [39:0] ivl_reg;
   logic [15:0] mix_reg;
   logic [SEQ_W-1:0] seq_sel_reg, seq_count_reg;
   logic [ADDR_W-1:0] mem_addr_reg;
   logic len_bad_reg;
   wps_entry_t seq_tab [SEQ_DEPTH];
   logic [ADDR_W-1:0] addr_cnt_reg;
   logic [LEN_W-1:0] len_cnt_reg;
   logic [REP_W-1:0] rep_cnt_reg;
   logic [SEQ_W-1:0] seq_idx_reg;
   logic [39:0] ivl_cnt_reg;
   logic trig_d_reg, evt_d_reg, gate_remote_reg;
   logic fetch_reg;
   logic [MEM_DW-1:0] mem_rdata;
   wps_word_t word_next, ser_out;

   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_PLAY} wps_state_t;
   wps_state_t state_reg;

   wps_mode_t mode;
   logic run, pol, trig_raw, trig_lvl, trig_edge, evt_lvl, evt_edge;
   logic cmd_trig, cmd_evt, cmd_jump, int_tick, trigger, gate, word_end;
   logic [LEN_W-1:0] len_chk;
   assign mode = wps_mode_t'(ctrl_reg[CB_MODE +: 2]);
   assign run = ctrl_reg[CB_RUN];
   assign pol = ctrl_reg[CB_POL];
   assign cmd_trig = wr && addr == R_CMD && wdata[CMD_TRIG];
   assign cmd_evt = wr && addr == R_CMD && wdata[CMD_EVENT];
   assign cmd_jump = wr && addr == R_CMD && wdata[CMD_JUMP];
   // Slave units take the master's registered trigger echo in place of pin and manual triggers, so they start one cycle after the master
   assign trig_raw = ctrl_reg[CB_SYNC_SLAVE] ? sync_trigger_in
                     : (external_trigger_input | force_trigger);
   assign trig_lvl = trig_raw ^ pol;
   assign trig_edge = trig_lvl && !trig_d_reg;
   assign evt_lvl = event_input | force_event;
   assign evt_edge = evt_lvl && !evt_d_reg;
   assign int_tick = ctrl_reg[CB_INT_TRIG] && ivl_cnt_reg == 40'h0000000000;
   assign trigger = trig_edge || cmd_trig || int_tick;
   assign gate = trig_lvl || gate_remote_reg;
   assign word_end = len_cnt_reg <= LEN_W'(LANES);
   assign len_chk = LEN_W'(wdata);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trig_d_reg <= 1'b0;
         evt_d_reg <= 1'b0;
      end else begin
         trig_d_reg <= trig_lvl;
         evt_d_reg <= evt_lvl;
      end
   end

   // Internal trigger interval, clamped into the allowed span
   always_ff @(posedge ref_clk) begin
      if (srst || !ctrl_reg[CB_INT_TRIG] || int_tick) begin
         ivl_cnt_reg <= ivl_reg;
      end else begin
         ivl_cnt_reg <= ivl_cnt_reg - 40'h0000000001;
      end
   end

   // Register writes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RESET;
         start_reg <= '0;
         len_reg <= MIN_LEN;
         rep_reg <= 16'h0001;
         ivl_reg <= 40'(TRIG_MIN - 1);
         mix_reg <= 16'h8080;
         seq_sel_reg <= '0;
         seq_count_reg <= '0;
         mem_addr_reg <= '0;
         len_bad_reg <= 1'b0;
         gate_remote_reg <= 1'b0;
      end else if (wr) begin
         case (addr)
            R_CTRL: ctrl_reg <= wdata;
            R_START: start_reg <= ADDR_W'(wdata);
            R_LENGTH: begin
               // Bad lengths are refused and flagged, old length kept
               if (len_chk < MIN_LEN || len_chk[1:0] != 2'b00 ||
                   len_chk > LEN_W'(LANES << ADDR_W)) begin
                  len_bad_reg <= 1'b1;
               end else begin
                  len_reg <= len_chk;
                  len_bad_reg <= 1'b0;
               end
            end
            R_REPEAT: rep_reg <= REP_W'(wdata);
            R_TRIG_IVL: begin
               if (40'(wdata) < 40'(TRIG_MIN)) begin
                  ivl_reg <= 40'(TRIG_MIN - 1);
               end else if (40'(wdata) > 40'(TRIG_MAX)) begin
                  ivl_reg <= 40'(TRIG_MAX - 1);
               end else begin
                  ivl_reg <= 40'(wdata) - 40'h0000000001;
               end
            end
            R_MIX: mix_reg <= wdata[15:0];
            R_CMD: gate_remote_reg <= wdata[CMD_GATE];
            R_SEQ_SEL: seq_sel_reg <= SEQ_W'(wdata);
            R_SEQ_COUNT: seq_count_reg <= SEQ_W'(wdata);
            R_MEM_ADDR: mem_addr_reg <= ADDR_W'(wdata);
            R_MEM_DATA: mem_addr_reg <= mem_addr_reg + 1'b1;
            default: ;
         endcase
      end
   end

   // Sequence table written one field at a time through the selected entry
   always_ff @(posedge ref_clk) begin
      if (wr) begin
         case (addr)
            R_SEQ_START: seq_tab[seq_sel_reg].start <= ADDR_W'(wdata);
            R_SEQ_LEN: seq_tab[seq_sel_reg].len <= LEN_W'(wdata);
            R_SEQ_REP: seq_tab[seq_sel_reg].rep <= REP_W'(wdata);
            R_SEQ_FLAGS: begin
               seq_tab[seq_sel_reg].wait_trig <= wdata[8];
               seq_tab[seq_sel_reg].jump <= SEQ_W'(wdata);
            end
            default: ;
         endcase
      end
   end

   // Playback control
   always_ff @(posedge ref_clk) begin
      if (srst || !run) begin
         state_reg <= S_IDLE;
         addr_cnt_reg <= '0;
         len_cnt_reg <= '0;
         rep_cnt_reg <= '0;
         seq_idx_reg <= '0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               seq_idx_reg <= '0;
               state_reg <= S_WAIT;
            end
            S_WAIT: begin
               // Start condition depends on the selected mode
               if (mode == WPS_CONT || (mode == WPS_TRIG && trigger) ||
                   (mode == WPS_GATED && gate) ||
                   (mode == WPS_SEQ && (!seq_tab[seq_idx_reg].wait_trig || trigger))) begin
                  state_reg <= S_PLAY;
                  if (mode == WPS_SEQ) begin
                     addr_cnt_reg <= seq_tab[seq_idx_reg].start;
                     len_cnt_reg <= seq_tab[seq_idx_reg].len;
                     rep_cnt_reg <= seq_tab[seq_idx_reg].rep;
                  end else begin
                     addr_cnt_reg <= start_reg;
                     len_cnt_reg <= len_reg;
                     rep_cnt_reg <= rep_reg;
                  end
               end
            end
            S_PLAY: begin
               if (mode == WPS_GATED && !gate) begin
                  state_reg <= S_WAIT;
               end else if (mode == WPS_SEQ && (evt_edge || cmd_evt || cmd_jump)) begin
                  // Jump target equal to own index stops output
                  if (seq_tab[seq_idx_reg].jump == seq_idx_reg) begin
                     state_reg <= S_IDLE;
                  end else begin
                     seq_idx_reg <= seq_tab[seq_idx_reg].jump;
                     state_reg <= S_WAIT;
                  end
               end else if (!word_end) begin
                  addr_cnt_reg <= addr_cnt_reg + 1'b1;
                  len_cnt_reg <= len_cnt_reg - LEN_W'(LANES);
               end else if (mode == WPS_CONT) begin
                  addr_cnt_reg <= start_reg;
                  len_cnt_reg <= len_reg;
               end else if (rep_cnt_reg > 16'h0001) begin
                  rep_cnt_reg <= rep_cnt_reg - 1'b1;
                  addr_cnt_reg <= (mode == WPS_SEQ) ? seq_tab[seq_idx_reg].start : start_reg;
                  len_cnt_reg <= (mode == WPS_SEQ) ? seq_tab[seq_idx_reg].len : len_reg;
               end else if (mode == WPS_SEQ) begin
                  seq_idx_reg <= (seq_idx_reg >= seq_count_reg) ? '0 : seq_idx_reg + 1'b1;
                  state_reg <= S_WAIT;
               end else begin
                  state_reg <= S_WAIT;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fetch_reg <= 1'b0;
      end else begin
         fetch_reg <= state_reg == S_PLAY && run;
      end
   end

   wps_mem #(.AW(ADDR_W), .DW(MEM_DW)) wps_mem_inst (
      .ref_clk(ref_clk),
      .we(wr && addr == R_MEM_DATA),
      .waddr(mem_addr_reg),
      .wdata(MEM_DW'(wdata)),
      .raddr(addr_cnt_reg),
      .rdata(mem_rdata)
   );

   // Mixing: value = (A*wa + B*wb) >> 8; B is the point two lanes on, 17 bits avoid overflow
   always_comb begin
      word_next.valid = fetch_reg;
      for (int i = 0; i < LANES; i++) begin
         word_next.pt[i] = wps_point_t'(mem_rdata[i*10 +: 10]);
         if (ctrl_reg[CB_MIX]) begin
            word_next.pt[i].value = 8'((17'(mem_rdata[i*10 +: 8]) * 17'(mix_reg[7:0]) +
                                        17'(mem_rdata[((i+2)%LANES)*10 +: 8]) * 17'(mix_reg[15:8])) >> 8);
         end
      end
   end

   wps_ser wps_ser_inst (
      .ref_clk(ref_clk),
      .srst(srst),
      .word_in(word_next),
      .word_reg_out(ser_out)
   );

   // Enables are plain register bits so toggling them never disturbs the counters
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dac_word <= '0;
         channel_output_enable <= 1'b0;
         channel_output_n_enable <= 1'b0;
         marker_output_enable <= 1'b0;
         running <= 1'b0;
         sync_trigger_out <= 1'b0;
      end else begin
         dac_word <= ser_out;
         channel_output_enable <= ctrl_reg[CB_OUT_EN];
         channel_output_n_enable <= ctrl_reg[CB_OUTN_EN];
         marker_output_enable <= ctrl_reg[CB_MARK_EN];
         running <= run;
         sync_trigger_out <= trigger;
      end
   end

   // Read data registered straight from the strobe, standing one cycle only
   always_ff @(posedge ref_clk) begin
      if (srst || !rd) begin
         rdata <= '0;
      end else begin
         case (addr)
            R_CTRL: rdata <= ctrl_reg;
            R_STATUS: rdata <= {20'h00000, seq_idx_reg, 5'h00, len_bad_reg, state_reg};
            R_START: rdata <= 32'(start_reg);
            R_LENGTH: rdata <= 32'(len_reg);
            R_REPEAT: rdata <= 32'(rep_reg);
            R_TRIG_IVL: rdata <= 32'(ivl_reg + 40'h0000000001);
            R_MIX: rdata <= 32'(mix_reg);
            R_SEQ_SEL: rdata <= 32'(seq_sel_reg);
            R_SEQ_COUNT: rdata <= 32'(seq_count_reg);
            R_MEM_ADDR: rdata <= 32'(addr_cnt_reg);
            default: rdata <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: hw/wps_pkg.sv
// Purpose: shared constants and types for the waveform playback sequencer
// Assumes: one clock, ref_clk, standing in for the sample clock divided by four
// Notes: one memory word carries four sample points
package wps_pkg;
   localparam int SAMPLE_W = 8;
   localparam int MARK_W = 2;
   localparam int LANES = 4;
   localparam int ADDR_W = 16;
   localparam int LEN_W = 24;
   localparam int REP_W = 16;
   localparam int SEQ_W = 4;
   localparam logic [LEN_W-1:0] MIN_LEN = 24'h0003C0;
   localparam logic [LEN_W-1:0] LEN_GRAIN = 24'h000004;
   localparam int CLK_PS = 8000;
   localparam longint TRIG_MIN_PS = 64'd1000000;
   localparam longint TRIG_MAX_PS = 64'd10000000000000;
   localparam longint TRIG_MIN_CYC = (TRIG_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam longint TRIG_MAX_CYC = TRIG_MAX_PS / CLK_PS;
   localparam logic [7:0] R_CTRL = 8'h00;
   localparam logic [7:0] R_STATUS = 8'h04;
   localparam logic [7:0] R_START = 8'h08;
   localparam logic [7:0] R_LENGTH = 8'h0C;
   localparam logic [7:0] R_REPEAT = 8'h10;
   localparam logic [7:0] R_TRIG_IVL = 8'h14;
   localparam logic [7:0] R_MIX = 8'h18;
   localparam logic [7:0] R_CMD = 8'h1C;
   localparam logic [7:0] R_SEQ_SEL = 8'h20;
   localparam logic [7:0] R_SEQ_START = 8'h24;
   localparam logic [7:0] R_SEQ_LEN = 8'h28;
   localparam logic [7:0] R_SEQ_REP = 8'h2C;
   localparam logic [7:0] R_SEQ_FLAGS = 8'h30;
   localparam logic [7:0] R_SEQ_COUNT = 8'h34;
   localparam logic [7:0] R_MEM_ADDR = 8'h38;
   localparam logic [7:0] R_MEM_DATA = 8'h3C;
   localparam int CB_RUN = 0;
   localparam int CB_MODE = 1;
   localparam int CB_OUT_EN = 3;
   localparam int CB_OUTN_EN = 4;
   localparam int CB_MARK_EN = 5;
   localparam int CB_POL = 6;
   localparam int CB_INT_TRIG = 7;
   localparam int CB_MIX = 8;
   localparam int CB_SYNC_SLAVE = 9;
   localparam int CMD_TRIG = 0;
   localparam int CMD_EVENT = 1;
   localparam int CMD_JUMP = 2;
   localparam int CMD_GATE = 3;
   localparam logic [31:0] CTRL_RESET = 32'h00000038;
   typedef enum logic [1:0] {WPS_CONT, WPS_TRIG, WPS_GATED, WPS_SEQ} wps_mode_t;
   typedef struct packed {
      logic [MARK_W-1:0] mark;
      logic [SAMPLE_W-1:0] value;
   } wps_point_t;
   typedef struct packed {
      logic [ADDR_W-1:0] start;
      logic [LEN_W-1:0] len;
      logic [REP_W-1:0] rep;
      logic wait_trig;
      logic [SEQ_W-1:0] jump;
   } wps_entry_t;
   typedef struct packed {
      logic valid;
      wps_point_t [3:0] pt;
   } wps_word_t;
endpackage

// File: hw/wps_mem.sv
// Purpose: sample memory, one word of four points per address
// Assumes: one write port from software, one read port for playback
// Notes: read data registered, one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module wps_mem #(
   parameter int AW = wps_pkg::ADDR_W,
   parameter int DW = 40
) (
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   import wps_pkg::*;
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// File: hw/wps_ser.sv
// Purpose: four-to-one serializer toward the DAC
// Assumes: fast_clk runs at four times the word rate
// Notes: lane 0 leaves first; the fast side is the sample clock itself
`timescale 1ns/100ps
`default_nettype none
module wps_ser (
   input wire logic ref_clk,
   input wire logic srst,
   input wire wps_pkg::wps_word_t word_in,
   output wps_pkg::wps_word_t word_reg_out
);
   import wps_pkg::*;
   // Word register handed to the DAC-side shift chain, lanes ascending
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         word_reg_out <= '0;
      end else begin
         word_reg_out <= word_in;
      end
   end
endmodule
`default_nettype wire

// File: bench/wps_checker.sv
// Purpose: port-level assertions for the playback sequencer
// Assumes: one clock domain, srst synchronous and active high
// Notes: a CTRL shadow predicts read data and the enable levels
`timescale 1ns/100ps
`default_nettype none
module wps_checker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic force_trigger,
   input wire logic external_trigger_input,
   input wire logic sync_trigger_out,
   input wire wps_pkg::wps_word_t dac_word,
   input wire logic channel_output_enable,
   input wire logic channel_output_n_enable,
   input wire logic marker_output_enable,
   input wire logic running
);
   import wps_pkg::*;
   logic [31:0] ctrl_shadow;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge ref_clk) begin
      if (srst)
         ctrl_shadow <= CTRL_RESET;
      else if (wr && addr == R_CTRL)
         ctrl_shadow <= wdata;
   end
   ctrl_read_a: assert property (rd && addr == R_CTRL |=> rdata[9:0] == ctrl_shadow[9:0])
      else $error("control read differs from last write");
   out_en_a: assert property (wr && addr == R_CTRL |-> ##2 channel_output_enable == ctrl_shadow[CB_OUT_EN])
      else $error("output enable does not follow control");
   outn_en_a: assert property (wr && addr == R_CTRL |-> ##2 channel_output_n_enable == ctrl_shadow[CB_OUTN_EN])
      else $error("complement enable does not follow control");
   mark_en_a: assert property (wr && addr == R_CTRL |-> ##2 marker_output_enable == ctrl_shadow[CB_MARK_EN])
      else $error("marker enable does not follow control");
   run_follow_a: assert property (wr && addr == R_CTRL |-> ##2 running == ctrl_shadow[CB_RUN])
      else $error("run indicator does not follow control");
   stop_drain_a: assert property ($fell(running) |-> ##[0:8] !dac_word.valid)
      else $error("samples keep flowing after stop");
   idle_quiet_a: assert property (!running [*8] |-> !dac_word.valid)
      else $error("samples while stopped");
   len_reject_a: assert property ((wr && addr == R_LENGTH && (wdata[23:0] < MIN_LEN || wdata[1:0] != 2'b00))
      ##2 (rd && addr == R_STATUS) |=> rdata[2])
      else $error("bad length not flagged");
   trig_echo_a: assert property ($rose(force_trigger || external_trigger_input) && !ctrl_shadow[CB_POL] &&
      !$past(ctrl_shadow[CB_POL]) && !ctrl_shadow[CB_SYNC_SLAVE] |-> ##1 sync_trigger_out)
      else $error("trigger not echoed");
   echo_pulse_a: assert property (sync_trigger_out |=> !sync_trigger_out)
      else $error("trigger echo longer than one cycle");
endmodule
bind wps_top wps_checker wps_checker_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .force_trigger(force_trigger), .sync_trigger_out(sync_trigger_out),
   .external_trigger_input(external_trigger_input),
   .dac_word(dac_word), .channel_output_enable(channel_output_enable),
   .channel_output_n_enable(channel_output_n_enable), .marker_output_enable(marker_output_enable),
   .running(running));
`default_nettype wire

// File: bench/wps_dac_model.sv
// Purpose: serializer and converter stand-in at the far side
// Assumes: sample clock free running at four times ref_clk
// Notes: between words the sample line toggles on every sample clock, starting from the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module wps_dac_model (
   input wire logic ref_clk,
   input wire logic srst,
   input wire wps_pkg::wps_word_t dac_word,
   output logic [wps_pkg::SAMPLE_W-1:0] dac_sample,
   output int n_words
);
   import wps_pkg::*;
   logic fast_clk = 1'b0;
   wps_point_t [3:0] hold_q;
   int seq_no = 0;
   int seen_no = 0;
   int lane = 4;
   always #1 fast_clk = ~fast_clk;
   always @(posedge ref_clk) begin
      if (srst)
         n_words <= 0;
      else if (dac_word.valid) begin
         n_words <= n_words + 1;
         hold_q <= dac_word.pt;
         seq_no <= seq_no + 1;
      end
   end
   // Lane 0 leaves first, one point per sample clock
   always @(posedge fast_clk) begin
      if (seen_no != seq_no) begin
         seen_no = seq_no;
         lane = 0;
      end
      if (lane < 4) begin
         dac_sample <= hold_q[lane].value;
         lane = lane + 1;
      end else
         dac_sample <= ~dac_sample;
   end
endmodule
`default_nettype wire

// File: bench/waveform_playback_sequencer_tb.sv
// Purpose: self-checking bench for the playback sequencer
// Assumes: 240-word waveform at address 0; upper 8 bits of each word stay zero
// Notes: mixing is left to later benches; the sequence table gets one entry
`timescale 1ns/100ps
`default_nettype none
module waveform_playback_sequencer_tb;
   import wps_pkg::*;
   localparam int NW = 240;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic external_trigger_input = 1'b0;
   logic force_trigger = 1'b0;
   logic evt_in = 1'b0;
   logic [31:0] rdata;
   logic sync_trigger_out;
   wps_word_t dac_word;
   logic coe;
   logic cone;
   logic moe;
   logic running;
   logic [31:0] mem_q [NW];
   int n_errors = 0;
   int total_checks = 0;
   int idx = 0;
   int n_words;
   logic watch = 1'b0;
   always #4 ref_clk = ~ref_clk;
   wps_top #(.TRIG_MIN(4)) wps_top_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .external_trigger_input(external_trigger_input),
      .event_input(evt_in), .force_trigger(force_trigger), .force_event(1'b0), .sync_trigger_in(1'b0),
      .sync_trigger_out(sync_trigger_out), .dac_word(dac_word), .channel_output_enable(coe),
      .channel_output_n_enable(cone), .marker_output_enable(moe), .running(running));
   wps_dac_model wps_dac_model_inst (.ref_clk(ref_clk), .srst(srst), .dac_word(dac_word),
      .dac_sample(), .n_words(n_words));
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      d = rdata;
   endtask
   // Words expected from one start: a repeat of 0 or 1 plays once
   function automatic int play_words(input int reps);
      return (reps > 1 ? reps : 1) * NW;
   endfunction
   task automatic fire(input int s);
      if (s == 2)
         wreg(R_CMD, 32'h00000001);
      else begin
         @(posedge ref_clk);
         if (s == 1)
            force_trigger <= 1'b1;
         else
            external_trigger_input <= (s == 0);
         repeat (2) @(posedge ref_clk);
         force_trigger <= 1'b0;
         external_trigger_input <= (s == 3);
      end
   endtask
   task automatic wait_words(input int target);
      for (int i = 0; i < 4000 && n_words < target; i++)
         @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
      check(n_words, target);
   endtask
   // Sampled mid-cycle so registered outputs have settled
   always @(negedge ref_clk) begin
      if (watch && dac_word.valid === 1'b1) begin
         check(dac_word.pt, {8'h00, mem_q[idx]});
         idx = (idx + 1) % NW;
      end
   end
   initial begin
      #(8 * 40000);
      n_errors++;
      wrap_up();
   end
   initial begin
      logic [31:0] rv;
      int n0;
      void'($urandom(24825));
      foreach (mem_q[i])
         mem_q[i] = $urandom;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      rreg(R_CTRL, rv);
      check(rv, CTRL_RESET);
      wreg(R_LENGTH, 32'h000003C0);
      for (int b = 0; b < 2; b++) begin
         wreg(R_LENGTH, b ? 32'h000003C2 : 32'h000003BC);
         rreg(R_STATUS, rv);
         check(rv[2], 1'b1);
         rreg(R_LENGTH, rv);
         check(rv, 32'h000003C0);
      end
      wreg(R_MEM_ADDR, 32'h00000000);
      foreach (mem_q[i])
         wreg(R_MEM_DATA, mem_q[i]);
      wreg(R_START, 32'h00000000);
      wreg(R_REPEAT, 32'h00000001);
      watch = 1'b1;
      wreg(R_CTRL, CTRL_RESET | 32'h00000001);
      repeat (100) @(posedge ref_clk);
      fire(0);
      wreg(R_CTRL, 32'h00000001);
      repeat (3) @(posedge ref_clk);
      check({coe, cone, moe, running}, 4'h1);
      n0 = n_words;
      repeat (40) @(posedge ref_clk);
      check(n_words - n0, 40);
      wreg(R_CTRL, CTRL_RESET);
      repeat (12) @(posedge ref_clk);
      check(running, 1'b0);
      n0 = n_words;
      repeat (20) @(posedge ref_clk);
      check(n_words, n0);
      for (int s = 0; s < 4; s++) begin
         wreg(R_REPEAT, s == 0 ? 32'h00000003 : 32'h00000001);
         if (s == 3)
            external_trigger_input <= 1'b1;
         wreg(R_CTRL, CTRL_RESET | 32'h00000003 | (s == 3 ? 32'h00000040 : 32'h00000000));
         repeat (20) @(posedge ref_clk);
         check(n_words, n0);
         idx = 0;
         fire(s);
         n0 = n0 + play_words(s == 0 ? 3 : 1);
         wait_words(n0);
         wreg(R_CTRL, CTRL_RESET);
         external_trigger_input <= 1'b0;
         repeat (12) @(posedge ref_clk);
      end
      wreg(R_CTRL, CTRL_RESET | 32'h00000005);
      repeat (20) @(posedge ref_clk);
      check(n_words, n0);
      idx = 0;
      external_trigger_input <= 1'b1;
      repeat (60) @(posedge ref_clk);
      external_trigger_input <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check(n_words > n0, 1'b1);
      n0 = n_words;
      repeat (20) @(posedge ref_clk);
      check(n_words, n0);
      wreg(R_SEQ_START, 32'h00000000);
      wreg(R_SEQ_LEN, 32'h000003C0);
      wreg(R_SEQ_REP, 32'h00000002);
      wreg(R_SEQ_FLAGS, 32'h00000100);
      wreg(R_CTRL, CTRL_RESET | 32'h00000007);
      repeat (20) @(posedge ref_clk);
      check(n_words, n0);
      idx = 0;
      fire(1);
      n0 = n0 + play_words(2);
      wait_words(n0);
      fire(1);
      repeat (100) @(posedge ref_clk);
      evt_in <= 1'b1;
      @(posedge ref_clk);
      evt_in <= 1'b0;
      repeat (300) @(posedge ref_clk);
      check(n_words - n0 < NW, 1'b1);
      check(n_words > n0, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
